/* core/srs_chip.sv */
// self-timed static ram chip with memory status output
//
// Contract
// - status rises only after read data valid
// - status stays high until preset ends
// - status fall marks ready; clock waits
// - full status pulse every read or write
// - write only selected, clock high, strobe low
// - output gate low turns outputs off
`timescale 1ns/1ps
`default_nettype none
module srs_chip
   import srs_pkg::*;
#(
   parameter int ACCESS_CYCLES = ACCESS_CYC,
   parameter int PRESET_CYCLES = PRESET_CYC
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire srs_pins_t pins,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   output logic chip_status_out
);
   localparam logic [CNT_W-1:0] ACC_LAST = CNT_W'(ACCESS_CYCLES);
   localparam logic [CNT_W-1:0] PRE_LAST = CNT_W'(PRESET_CYCLES);

   // ------------------------------------------------------------
   // pin synchronisation
   // ------------------------------------------------------------
   logic [PINS_W-1:0] pins_sync;
   srs_pins_t p;
   logic ce_prev_q;
   logic ce_rise;

   srs_sync #(
      .W(PINS_W)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .async_in(pins),
      .sync_out(pins_sync)
   );

   assign p = srs_pins_t'(pins_sync);
   // detector resets low, the idle clock level, so reset makes no false cycle
   assign ce_rise = p.chip_enable & ~ce_prev_q;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         ce_prev_q <= 1'b0;
      else
         ce_prev_q <= p.chip_enable;
   end

   // ------------------------------------------------------------
   // cycle sequencer
   // ------------------------------------------------------------
   srs_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic sel_q, sel_d;
   logic status_q, status_d;
   logic valid_q, valid_d;
   logic [DATA_W-1:0] dout_q, dout_d;
   logic oe_q, oe_d;
   logic wr_en;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // the access phase gates both writing and the output buffer
   function automatic logic in_access(input srs_state_t s);
      return s == ST_ACCESS;
   endfunction

   assign wr_en = in_access(state_q) & sel_q & p.chip_enable & ~p.write_enable_n;

   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      sel_d = sel_q;
      status_d = status_q;
      valid_d = valid_q;
      dout_d = dout_q;
      case (state_q)
         ST_IDLE:
         begin
            // new cycle only on a fresh clock rise after preset
            if (ce_rise)
            begin
               state_d = ST_ACCESS;
               cnt_d = CNT_ONE;
               addr_d = p.address;
               sel_d = ~p.chip_select_n;
               valid_d = 1'b0;
            end
         end
         ST_ACCESS:
         begin
            if (cnt_q >= ACC_LAST)
            begin
               // data registered here, status rises one cycle later
               dout_d = wr_en ? p.data_in : mem[addr_q];
               valid_d = 1'b1;
               state_d = ST_HOLD;
            end
            else
               cnt_d = cnt_q + CNT_ONE;
         end
         ST_HOLD:
         begin
            // every cycle, read or write, raises status
            status_d = 1'b1;
            // preset begins only once the clock is low
            if (status_q & ~p.chip_enable)
            begin
               state_d = ST_PRESET;
               cnt_d = CNT_ONE;
            end
         end
         ST_PRESET:
         begin
            if (cnt_q >= PRE_LAST)
            begin
               status_d = 1'b0;
               state_d = ST_IDLE;
            end
            else
               cnt_d = cnt_q + CNT_ONE;
         end
         default:
         begin
            state_d = ST_IDLE;
            status_d = 1'b0;
            cnt_d = CNT_ZERO;
         end
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         cnt_q <= CNT_ZERO;
         addr_q <= '0;
         sel_q <= 1'b0;
         status_q <= 1'b0;
         valid_q <= 1'b0;
         dout_q <= DOUT_RST;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         sel_q <= sel_d;
         status_q <= status_d;
         valid_q <= valid_d;
         dout_q <= dout_d;
      end
   end

   // ------------------------------------------------------------
   // output buffer control
   // ------------------------------------------------------------
   // output controls pass the synchroniser, so they act three edges late
   // gate low, blank high or deselect each turns outputs off
   function automatic logic drive_allowed(input srs_pins_t pv, input logic sel);
      return sel & pv.output_gate & ~pv.output_blank;
   endfunction

   always_comb
   begin
      // outputs stay off until the access time is reached
      oe_d = valid_d & ~in_access(state_d) & drive_allowed(p, sel_d);
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         oe_q <= 1'b0;
      else
         oe_q <= oe_d;
   end

   // ------------------------------------------------------------
   // storage array
   // ------------------------------------------------------------
   // no reset: contents are undefined after power-up, as in the part
   always_ff @(posedge ref_clk)
   begin
      // store only on a selected, enabled, strobed cycle
      if (wr_en)
         mem[addr_q] <= p.data_in;
   end

   assign data_out = dout_q;
   assign data_oe = oe_q;
   assign chip_status_out = status_q;
endmodule
`default_nettype wire

/* core/srs_pkg.sv */
// shared constants and pin bundles for the self-timed static ram chip
package srs_pkg;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 4;
   // clock rate and internal timing of the chip
   localparam int CLK_PERIOD_NS = 100;
   localparam int ACCESS_NS = 300;
   localparam int PRESET_NS = 200;
   // least times, rounded up to whole cycles
   localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRESET_CYC = (PRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;
   localparam logic [DATA_W-1:0] DOUT_RST = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

   // control pins of one chip, all asynchronous to ref_clk
   typedef struct packed {
      logic chip_enable;
      logic chip_select_n;
      logic write_enable_n;
      logic output_gate;
      logic output_blank;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] data_in;
   } srs_pins_t;

   localparam int PINS_W = $bits(srs_pins_t);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACCESS = 2'b01,
      ST_HOLD = 2'b10,
      ST_PRESET = 2'b11
   } srs_state_t;
endpackage

/* core/srs_sync.sv */
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module srs_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule
`default_nettype wire

/* testbench/srs_chip_assertions.sv */
// concurrent checks on the status chip ports
`timescale 1ns/1ps
`default_nettype none
module srs_chip_chk
   import srs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire srs_pins_t pins,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic data_oe,
   input wire logic chip_status_out
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_strobe_after_data: assert property ($rose(chip_status_out) |-> $stable(data_out))
      else $error("status rose while data moved");
   a_hold_while_ce: assert property (chip_status_out && pins.chip_enable |=> chip_status_out)
      else $error("status fell with clock high");
   a_pulse_each_cycle: assert property ($rose(pins.chip_enable) && !chip_status_out |-> ##[3:12] chip_status_out)
      else $error("no status pulse for cycle");
   a_gate_off: assert property (!pins.output_gate [*4] |-> !data_oe)
      else $error("outputs on with gate low");
   a_blank_off: assert property (pins.output_blank [*4] |-> !data_oe)
      else $error("outputs on with blank high");
   a_status_falls: assert property ($fell(pins.chip_enable) && chip_status_out |-> ##[3:12] !chip_status_out)
      else $error("status did not fall after clock");
endmodule
bind srs_chip srs_chip_chk chk (.ref_clk(ref_clk), .rst(rst), .pins(pins), .data_out(data_out),
   .data_oe(data_oe), .chip_status_out(chip_status_out));
`default_nettype wire

/* testbench/srs_chip_tb.sv */
// self-checking bench for the status chip
`timescale 1ns/1ps
`default_nettype none
module srs_chip_tb
   import srs_pkg::*;
();
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   srs_pins_t pins;
   logic [DATA_W-1:0] data_out;
   logic data_oe;
   logic chip_status_out;
   logic prev_st = 1'b0;
   logic [DATA_W:0] e;
   logic [DATA_W:0] exp_q[$];
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [ADDR_W-1:0] ad [8];
   logic [7:0] lf = 8'h53;
   int err_total = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #50 ref_clk = ~ref_clk;
   srs_chip #(.ACCESS_CYCLES(ACCESS_CYC), .PRESET_CYCLES(PRESET_CYC)) uut (.ref_clk(ref_clk), .rst(rst),
      .pins(pins), .data_out(data_out), .data_oe(data_oe), .chip_status_out(chip_status_out));
   srs_ctrl_model m (.ref_clk(ref_clk), .chip_status_out(chip_status_out), .pins(pins));
   function automatic logic [7:0] nxt(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic chk(input string nm, input logic [DATA_W:0] ex, got);
      cmp_count++;
      if (got !== ex)
      begin
         err_total++;
         $display("mismatch %s exp %h got %h", nm, ex, got);
      end
   endtask
   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // expectation noted before the cycle starts
   task automatic op(input logic wr, cs_n, blank, input logic [ADDR_W-1:0] a, input int slow);
      lf = nxt(lf);
      if (wr && !cs_n)
         mem[a] = lf[3:0];
      exp_q.push_back((wr || cs_n || blank) ? {1'b0, lf[3:0]} : {1'b1, mem[a]});
      m.run(wr, cs_n, blank, a, lf[3:0], slow);
   endtask
   // output disabled cases check only the enable
   always @(posedge ref_clk)
   begin
      #1;
      if (chip_status_out === 1'b1 && prev_st === 1'b0)
      begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
         chk("strobe", e, {data_oe, e[DATA_W] ? data_out : e[DATA_W-1:0]});
      end
      prev_st = chip_status_out;
   end
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc > 3000)
      begin
         err_total++;
         summarize();
      end
   end
   initial
   begin
      #150;
      chk("reset", {1'b0, DOUT_RST}, {data_oe, data_out});
      #10 rst = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         lf = nxt(lf);
         ad[i] = {lf, i[1:0]};
         op(1'b1, 1'b0, 1'b0, ad[i], i % 3);
      end
      $display("test writes done");
      op(1'b1, 1'b1, 1'b0, ad[0], 0);
      for (int i = 0; i < 8; i++)
         op(1'b0, 1'b0, 1'b0, ad[i], i % 2);
      $display("test reads done");
      repeat (3) exp_q.push_back({1'b1, mem[ad[3]]});
      m.free_run(ad[3], 3);
      $display("test free run done");
      op(1'b0, 1'b1, 1'b0, ad[1], 0);
      op(1'b0, 1'b0, 1'b1, ad[2], 1);
      repeat (20) @(posedge ref_clk);
      chk("drained", '0, (DATA_W + 1)'(exp_q.size()));
      $display("test output controls done");
      summarize();
   end
endmodule
`default_nettype wire

/* testbench/srs_ctrl_model.sv */
// behavioural controller driving the chip pins
`timescale 1ns/1ps
`default_nettype none
module srs_ctrl_model
   import srs_pkg::*;
(
   input wire logic ref_clk,
   input wire logic chip_status_out,
   output var srs_pins_t pins
);
   logic [0:0] status_vec;
   logic all_hi;
   logic all_lo;
   logic sys_status = 1'b0;
   initial pins = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, '0, '0};
   // one bit per chip; chips in parallel widen the vector
   assign status_vec = chip_status_out;
   assign all_hi = &status_vec;
   assign all_lo = ~|status_vec;
   // set/reset latch, cleared at start, holds in between
   always @(all_hi, all_lo)
   begin
      if (all_hi)
         sys_status = 1'b1;
      else if (all_lo)
         sys_status = 1'b0;
   end
   // one-of-three row decode with all-off; chip is row 0
   function automatic logic [2:0] row_decode(input logic [1:0] a, input logic all_off);
      logic [2:0] r;
      r = 3'b000;
      if (!all_off && a != 2'b11)
         r[a] = 1'b1;
      return r;
   endfunction
   task automatic run(input logic wr, cs_n, blank, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input int slow);
      int n;
      logic [2:0] rows;
      // cs_n carries the row bit; low picks row 0, the chip's row
      rows = row_decode({1'b0, cs_n}, 1'b0);
      for (n = 0; n < 40 && chip_status_out !== 1'b0; n++) @(posedge ref_clk);
      @(posedge ref_clk);
      #10;
      pins = '{1'b1, !rows[0], !wr, !wr, blank, a, d};
      for (n = 0; n < 40 && chip_status_out !== 1'b1; n++) @(posedge ref_clk);
      repeat (slow) @(posedge ref_clk);
      #10;
      pins.chip_enable = 1'b0;
      // released data no longer valid
      pins.data_in = ~d;
   endtask
   // free run: the clock is the inverted system status
   task automatic free_run(input logic [ADDR_W-1:0] a, input int k);
      int n;
      int seen;
      seen = 0;
      for (n = 0; n < 40 && chip_status_out !== 1'b0; n++) @(posedge ref_clk);
      @(posedge ref_clk);
      #10;
      pins = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, a, '0};
      for (n = 0; n < 40 * k && seen < k; n++)
      begin
         @(posedge ref_clk);
         #10;
         if (pins.chip_enable && sys_status)
            seen++;
         pins.chip_enable = !sys_status && seen < k;
      end
   endtask
endmodule
`default_nettype wire
